// *** design/relay_safety_map.svh ***
// register map, field positions and reset values of the relay safety watchdog
// Operation
// - enabled trigger enters shutdown, relays take preset
// - shutdown stops automatic scanning at once
// - immediate-write updates ignored while shut down
// - recovery leaves shutdown, keeps pattern, rewinds scanlist
// - preset defaults all off, software rewritable
// - local shutdown input is active low
// - shutdown source: front panel or trigger bus
// - shutdown and watchdog disabled after reset
// - on-board 32-bit watchdog counter is default source
// - missed service raises overflow, relays take preset
// - watchdog trigger may come from trigger bus
// - hot-swap indicator lit until ready for operation
`ifndef RELAY_SAFETY_MAP_SVH
`define RELAY_SAFETY_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_PRESET 8'h0c
`define OFS_INTERVAL 8'h10
`define OFS_COUNT 8'h14
`define OFS_DIRECT 8'h18
`define OFS_INT_STATUS 8'h1c
`define OFS_INT_MASK 8'h20
`define OFS_RELAY 8'h24
`define OFS_SCAN_BASE 8'h40

// ------------------------------------------------------------
// command bits, interrupt bits, field widths
// ------------------------------------------------------------
`define CMD_SERVICE 0
`define CMD_RECOVER 1
`define CMD_SCAN_START 2
`define CMD_SCAN_STOP 3
`define CMD_READY 4
`define INT_SHUTDOWN 0
`define INT_OVERFLOW 1
`define INT_W 2
`define CTRL_W 11

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTRL_RST 11'h000
`define PRESET_RST 32'h0000_0000
`define INTERVAL_RST 32'hffff_ffff

`endif

// *** design/relay_safety_pkg.sv ***
// types shared by the relay safety watchdog
package relay_safety_pkg;

    // control register layout, bit 10 first from the top
    typedef struct packed {
        logic direct_mode;
        logic [2:0] wd_line;
        logic [2:0] sd_line;
        logic wd_from_bus;
        logic sd_from_bus;
        logic wd_en;
        logic sd_en;
    } ctrl_t;

    // one-cycle commands decoded from a command write
    typedef struct packed {
        logic ready;
        logic scan_stop;
        logic scan_start;
        logic recover;
        logic service;
    } cmd_t;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_SCAN,
        MODE_SHUTDOWN
    } mode_t;

endpackage

// *** design/relay_safety_shutdown_watchdog.sv ***
// relay safety logic: emergency shutdown, watchdog, scan and hot-swap indicator
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "relay_safety_map.svh"

module relay_safety_shutdown_watchdog #(
    parameter int RELAYS = 16,
    parameter int SCAN_DEPTH = 8,
    parameter int WDOG_W = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // trigger sources
    input wire logic shutdown_request_n,
    input wire logic [7:0] trig_bus,
    input wire logic scan_trigger,
    // outputs to the module
    output logic [RELAYS-1:0] relay_out,
    output logic wdog_overflow,
    output logic shutdown_active,
    output logic hot_swap_led,
    output logic irq
);

    localparam int IDXW = (SCAN_DEPTH > 1) ? $clog2(SCAN_DEPTH) : 1;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (RELAYS < 1 || RELAYS > 32)
        $error("relay count must be 1 to 32");
    if (SCAN_DEPTH < 2 || SCAN_DEPTH > 16 || (1 << IDXW) != SCAN_DEPTH)
        $error("scan depth must be a power of two from 2 to 16");
    if (WDOG_W != 32)
        $error("watchdog counter is 32 bits wide");

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // bus lines are open collector, so a low line is a request
    function automatic logic bus_low(input logic [7:0] lines, input logic [2:0] idx);
        bus_low = ~lines[idx];
    endfunction
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction
    function automatic logic scan_hit(input logic [7:0] addr);
        scan_hit = (addr >= `OFS_SCAN_BASE)
            && ({1'b0, addr} < 9'(`OFS_SCAN_BASE) + 9'(4 * SCAN_DEPTH))
            && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    relay_safety_pkg::ctrl_t ctrl_reg, ctrl_next;
    logic [RELAYS-1:0] preset_reg, preset_next;
    logic [WDOG_W-1:0] interval_reg, interval_next;
    logic [WDOG_W-1:0] count_reg, count_next;
    logic overflow_reg, overflow_next;
    relay_safety_pkg::mode_t mode_reg, mode_next;
    logic [IDXW-1:0] ptr_reg, ptr_next;
    logic [RELAYS-1:0] relay_reg, relay_next;
    logic [`INT_W-1:0] int_status_reg, int_status_next;
    logic [`INT_W-1:0] int_mask_reg, int_mask_next;
    logic irq_reg, irq_next;
    logic led_reg, led_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [RELAYS-1:0] scan_mem [SCAN_DEPTH];
    logic sd_reg, sd_next;
    relay_safety_pkg::cmd_t cmd;
    logic sd_trigger;
    logic wd_trigger;
    logic trip;
    logic cfg_touch;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    always_comb
    begin
        cmd = '0;
        if (reg_wr && hit(reg_addr, `OFS_CMD))
        begin
            cmd.service = reg_wdata[`CMD_SERVICE];
            cmd.recover = reg_wdata[`CMD_RECOVER];
            cmd.scan_start = reg_wdata[`CMD_SCAN_START];
            cmd.scan_stop = reg_wdata[`CMD_SCAN_STOP];
            cmd.ready = reg_wdata[`CMD_READY];
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        preset_next = preset_reg;
        interval_next = interval_reg;
        int_mask_next = int_mask_reg;
        if (reg_wr && hit(reg_addr, `OFS_CTRL))
            ctrl_next = relay_safety_pkg::ctrl_t'(reg_wdata[`CTRL_W-1:0]);
        if (reg_wr && hit(reg_addr, `OFS_PRESET))
            preset_next = reg_wdata[RELAYS-1:0];
        if (reg_wr && hit(reg_addr, `OFS_INTERVAL))
            interval_next = reg_wdata[WDOG_W-1:0];
        if (reg_wr && hit(reg_addr, `OFS_INT_MASK))
            int_mask_next = reg_wdata[`INT_W-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= `CTRL_RST;
            preset_reg <= RELAYS'(`PRESET_RST);
            interval_reg <= `INTERVAL_RST;
            int_mask_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            preset_reg <= preset_next;
            interval_reg <= interval_next;
            int_mask_reg <= int_mask_next;
        end
    end
    // scanlist storage; no reset so it can map to ram
    always_ff @(posedge core_clk)
    begin
        if (reg_wr && scan_hit(reg_addr))
            scan_mem[reg_addr[2 +: IDXW]] <= reg_wdata[RELAYS-1:0];
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    // any rewrite of control or interval counts as reconfiguring
    assign cfg_touch = reg_wr && (hit(reg_addr, `OFS_CTRL) || hit(reg_addr, `OFS_INTERVAL));
    always_comb
    begin
        count_next = count_reg;
        overflow_next = overflow_reg;
        if (!ctrl_reg.wd_en || cfg_touch)
        begin
            count_next = interval_next;
            overflow_next = 1'b0;
        end
        else if (!overflow_reg)
        begin
            if (cmd.service)
                count_next = interval_reg;
            else if (count_reg == '0)
                overflow_next = 1'b1;
            else
                count_next = count_reg - 1'b1;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count_reg <= `INTERVAL_RST;
            overflow_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            overflow_reg <= overflow_next;
        end
    end

    // ------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------
    // a low level holds shutdown; sharers of the aux pin must not pull it low
    assign sd_trigger = ctrl_reg.sd_en && (ctrl_reg.sd_from_bus
        ? bus_low(trig_bus, ctrl_reg.sd_line)
        : ~shutdown_request_n);
    assign wd_trigger = ctrl_reg.wd_en && (ctrl_reg.wd_from_bus
        ? bus_low(trig_bus, ctrl_reg.wd_line)
        : overflow_reg);
    assign trip = sd_trigger || wd_trigger;

    // ------------------------------------------------------------
    // mode, scan, relay pattern and hot-swap indicator
    // ------------------------------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        ptr_next = ptr_reg;
        relay_next = relay_reg;
        led_next = led_reg;
        if (cmd.ready)
            led_next = 1'b0;
        if (trip)
        begin
            // a held trigger wins over recovery in the same cycle
            mode_next = relay_safety_pkg::MODE_SHUTDOWN;
            relay_next = preset_reg;
        end
        else
        begin
            unique case (mode_reg)
                relay_safety_pkg::MODE_SHUTDOWN:
                begin
                    // no scan steps or direct writes land here
                    if (cmd.recover)
                    begin
                        mode_next = relay_safety_pkg::MODE_IDLE;
                        ptr_next = '0;
                    end
                end
                relay_safety_pkg::MODE_IDLE:
                begin
                    if (cmd.scan_start && !ctrl_reg.direct_mode)
                        mode_next = relay_safety_pkg::MODE_SCAN;
                    if (ctrl_reg.direct_mode && reg_wr && hit(reg_addr, `OFS_DIRECT))
                        relay_next = reg_wdata[RELAYS-1:0];
                end
                relay_safety_pkg::MODE_SCAN:
                begin
                    if (cmd.scan_stop)
                        mode_next = relay_safety_pkg::MODE_IDLE;
                    else if (scan_trigger)
                    begin
                        relay_next = scan_mem[ptr_reg];
                        ptr_next = ptr_reg + 1'b1;
                    end
                end
            endcase
        end
        sd_next = (mode_next == relay_safety_pkg::MODE_SHUTDOWN);
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mode_reg <= relay_safety_pkg::MODE_IDLE;
            ptr_reg <= '0;
            relay_reg <= '0;
            sd_reg <= 1'b0;
            led_reg <= 1'b1;
        end
        else
        begin
            mode_reg <= mode_next;
            ptr_reg <= ptr_next;
            relay_reg <= relay_next;
            sd_reg <= sd_next;
            led_reg <= led_next;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        logic [`INT_W-1:0] set_bits;
        logic [`INT_W-1:0] clr_bits;
        set_bits = '0;
        clr_bits = '0;
        set_bits[`INT_SHUTDOWN] = trip && (mode_reg != relay_safety_pkg::MODE_SHUTDOWN);
        set_bits[`INT_OVERFLOW] = overflow_next && !overflow_reg;
        if (reg_wr && hit(reg_addr, `OFS_INT_STATUS))
            clr_bits = reg_wdata[`INT_W-1:0];
        // set wins so an event in the clearing cycle survives
        int_status_next = (int_status_reg & ~clr_bits) | set_bits;
        irq_next = |(int_status_next & int_mask_next);
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            int_status_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            int_status_reg <= int_status_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_next = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                `OFS_CTRL: rdata_next = 32'(ctrl_reg);
                `OFS_STATUS: rdata_next = {24'h00_0000, 4'(ptr_reg), led_reg,
                    mode_reg == relay_safety_pkg::MODE_SCAN,
                    overflow_reg, mode_reg == relay_safety_pkg::MODE_SHUTDOWN};
                `OFS_PRESET: rdata_next = 32'(preset_reg);
                `OFS_INTERVAL: rdata_next = interval_reg;
                `OFS_COUNT: rdata_next = count_reg;
                `OFS_INT_STATUS: rdata_next = 32'(int_status_reg);
                `OFS_INT_MASK: rdata_next = 32'(int_mask_reg);
                `OFS_RELAY: rdata_next = 32'(relay_reg);
                default:
                    if (scan_hit(reg_addr))
                        rdata_next = 32'(scan_mem[reg_addr[2 +: IDXW]]);
            endcase
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign relay_out = relay_reg;
    assign wdog_overflow = overflow_reg;
    assign shutdown_active = sd_reg;
    assign hot_swap_led = led_reg;
    assign irq = irq_reg;

endmodule

// *** dv/relay_safety_sva.sv ***
// assertion checker for the relay safety watchdog ports
`timescale 1ns/1ps
`include "relay_safety_map.svh"
module relay_safety_sva #(
    parameter int RELAYS = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // lines and outputs
    input wire logic shutdown_request_n,
    input wire logic [7:0] trig_bus,
    input wire logic [RELAYS-1:0] relay_out,
    input wire logic wdog_overflow,
    input wire logic shutdown_active,
    input wire logic hot_swap_led
);
// ------------------------------------------------------------
// shadow of control and preset
// ------------------------------------------------------------
logic [10:0] ctrl_reg, ctrl_next;
logic [31:0] preset_reg, preset_next;
logic cmd_wr, cfg_wr;
always_comb
begin
    ctrl_next = ctrl_reg;
    preset_next = preset_reg;
    if (reg_wr && reg_addr == `OFS_CTRL)
        ctrl_next = reg_wdata[10:0];
    if (reg_wr && reg_addr == `OFS_PRESET)
        preset_next = reg_wdata;
    if (rst)
    begin
        ctrl_next = '0;
        preset_next = '0;
    end
    cmd_wr = reg_wr && reg_addr == `OFS_CMD;
    cfg_wr = reg_wr && (reg_addr == `OFS_CTRL || reg_addr == `OFS_INTERVAL);
end
always_ff @(posedge core_clk)
begin
    ctrl_reg <= ctrl_next;
    preset_reg <= preset_next;
end
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
// ------------------------------------------------------------
// properties
// ------------------------------------------------------------
AST_RST: assert property (disable iff (1'b0) rst |=> relay_out == '0 && hot_swap_led
    && !wdog_overflow && !shutdown_active) else $error("reset state wrong");
AST_SD_OFF: assert property (ctrl_reg[1:0] == 2'b00 && !shutdown_active && !reg_wr
    |=> !shutdown_active) else $error("shutdown while disabled");
AST_SD_LOCAL: assert property (ctrl_reg[0] && !ctrl_reg[2] && !shutdown_request_n
    && !reg_wr |=> shutdown_active) else $error("local low did not shut down");
AST_SD_BUS: assert property (ctrl_reg[0] && ctrl_reg[2] && !trig_bus[ctrl_reg[6:4]]
    && !reg_wr |=> shutdown_active) else $error("bus line did not shut down");
AST_WD_BUS: assert property (ctrl_reg[1] && ctrl_reg[3] && !trig_bus[ctrl_reg[9:7]]
    && !reg_wr |=> shutdown_active) else $error("bus watchdog ignored");
AST_WD_OVF: assert property (ctrl_reg[1] && !ctrl_reg[3] && wdog_overflow && !reg_wr
    |=> shutdown_active) else $error("overflow did not shut down");
AST_SD_PRESET: assert property ($rose(shutdown_active)
    |-> relay_out == preset_reg[RELAYS-1:0]) else $error("relay not at preset");
AST_SD_FROZEN: assert property (shutdown_active |=> $stable(relay_out))
    else $error("relay moved in shutdown");
AST_RECOVER_KEEP: assert property ($fell(shutdown_active) && !$past(rst)
    |-> $stable(relay_out)) else $error("recovery moved relay");
AST_WD_OFF: assert property (!ctrl_reg[1] |-> !wdog_overflow)
    else $error("overflow with watchdog off");
AST_OVF_HOLD: assert property (wdog_overflow && !cfg_wr |=> wdog_overflow)
    else $error("overflow dropped");
AST_LED_OFF: assert property (cmd_wr && reg_wdata[`CMD_READY] |=> !hot_swap_led)
    else $error("led not off after ready");
AST_LED_ON: assert property (hot_swap_led && !(cmd_wr && reg_wdata[`CMD_READY])
    |=> hot_swap_led) else $error("led off too early");
AST_LED_STAY: assert property (!hot_swap_led |=> !hot_swap_led)
    else $error("led relit");
endmodule
bind relay_safety_shutdown_watchdog relay_safety_sva #(.RELAYS(RELAYS)) relay_safety_sva_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .shutdown_request_n(shutdown_request_n), .trig_bus(trig_bus),
    .relay_out(relay_out), .wdog_overflow(wdog_overflow),
    .shutdown_active(shutdown_active), .hot_swap_led(hot_swap_led));

// *** dv/relay_safety_partner.sv ***
// partner model: front-panel button and backplane trigger lines
`timescale 1ns/1ps
module relay_safety_partner (
    // clock
    input wire logic core_clk,
    // commands from the bench
    input wire logic press,
    input wire logic [7:0] pull_bus,
    // pulled-up lines toward the block
    output logic shutdown_request_n,
    output logic [7:0] trig_bus
);
// ------------------------------------------------------------
// open-collector lines
// ------------------------------------------------------------
// released lines float back high through the pull-ups;
// pulled low only on command, never as a spare output
always @(posedge core_clk)
begin
    shutdown_request_n <= !press;
    trig_bus <= ~pull_bus;
end
endmodule

// *** dv/relay_safety_shutdown_watchdog_tb.sv ***
// self-checking bench of the relay safety watchdog
`timescale 1ns/1ps
`include "relay_safety_map.svh"
module relay_safety_shutdown_watchdog_tb;
// ------------------------------------------------------------
// signals and model state
// ------------------------------------------------------------
logic core_clk = 1'b0;
logic rst = 1'b1;
logic [7:0] reg_addr = 8'h00;
logic [31:0] reg_wdata = 32'h0;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic scan_trigger = 1'b0;
logic press = 1'b0;
logic [7:0] pull_bus = 8'h00;
logic [31:0] reg_rdata, d;
logic shutdown_request_n, wdog_overflow, shutdown_active, hot_swap_led, irq;
logic [7:0] trig_bus;
logic [15:0] relay_out;
int num_errors = 0;
int check_count = 0;
int seed = 32'h6fa8;
int scan_q[$];
int preset, exp_relay;
logic [7:0] ra[5] = '{`OFS_CTRL, `OFS_PRESET, `OFS_INTERVAL, `OFS_STATUS, 8'h3c};
logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hffff_ffff, 32'h8, 32'h0};
relay_safety_shutdown_watchdog #(.SCAN_DEPTH(4)) relay_safety_shutdown_watchdog_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shutdown_request_n(shutdown_request_n), .trig_bus(trig_bus),
    .scan_trigger(scan_trigger), .relay_out(relay_out), .wdog_overflow(wdog_overflow),
    .shutdown_active(shutdown_active), .hot_swap_led(hot_swap_led), .irq(irq));
relay_safety_partner relay_safety_partner_i (.core_clk(core_clk), .press(press),
    .pull_bus(pull_bus), .shutdown_request_n(shutdown_request_n), .trig_bus(trig_bus));
initial
begin
    forever #10 core_clk = ~core_clk;
end
// ------------------------------------------------------------
// tasks
// ------------------------------------------------------------
task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
endtask
task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
endtask
task automatic pulse;
    scan_trigger <= 1'b1;
    @(posedge core_clk);
    scan_trigger <= 1'b0;
    #1 d = 32'(relay_out);
    @(posedge core_clk);
endtask
// bounded wait; a miss ends the run at once
task automatic wait_sd;
    repeat (20)
    begin
        @(posedge core_clk);
        #1;
        if (shutdown_active === 1'b1)
            break;
    end
    if (shutdown_active !== 1'b1)
    begin
        chk("shutdown entry", shutdown_active, 1'b1);
        complete_run();
    end
endtask
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
initial
begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (ra[i])
    begin
        rd(ra[i]);
        chk("reset read", d, rv[i]);
    end
    preset = $random(seed) & 32'hffff;
    wr(`OFS_PRESET, preset);
    rd(`OFS_PRESET);
    chk("preset", d, preset);
    for (int i = 0; i < 4; i++)
    begin
        scan_q.push_back($random(seed) & 32'hffff);
        wr(`OFS_SCAN_BASE + 8'(4 * i), scan_q[i]);
    end
    wr(`OFS_INT_MASK, 32'h3);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_CMD, 32'h4);
    for (int i = 0; i < 5; i++)
    begin
        pulse();
        chk("scan relay", d, scan_q[i % 4]);
    end
    rd(`OFS_STATUS);
    chk("scanning", d, 32'h1c);
    press <= 1'b1;
    wait_sd();
    chk("sd relay", relay_out, preset);
    chk("irq", irq, 1'b1);
    @(posedge core_clk);
    press <= 1'b0;
    repeat (3) @(posedge core_clk);
    pulse();
    chk("frozen", d, preset);
    wr(`OFS_CMD, 32'h2);
    rd(`OFS_STATUS);
    chk("recovered", d, 32'h8);
    chk("kept", relay_out, preset);
    rd(`OFS_INT_STATUS);
    chk("int set", d, 32'h1);
    wr(`OFS_INT_STATUS, 32'h1);
    rd(`OFS_INT_STATUS);
    chk("int clear", d, 32'h0);
    chk("irq clear", irq, 1'b0);
    wr(`OFS_CMD, 32'h4);
    pulse();
    chk("rewound", d, scan_q[0]);
    wr(`OFS_CMD, 32'h8);
    pulse();
    chk("stopped", d, scan_q[0]);
    // immediate-write mode, shutdown from bus line 3, shutdown irq masked
    wr(`OFS_INT_MASK, 32'h2);
    wr(`OFS_CTRL, 32'h435);
    exp_relay = $random(seed) & 32'hffff;
    wr(`OFS_DIRECT, exp_relay);
    chk("direct", relay_out, exp_relay);
    pull_bus <= 8'h08;
    wait_sd();
    chk("bus sd", relay_out, preset);
    chk("masked irq", irq, 1'b0);
    @(posedge core_clk);
    pull_bus <= 8'h00;
    repeat (3) @(posedge core_clk);
    wr(`OFS_DIRECT, ~exp_relay);
    chk("locked", relay_out, preset);
    wr(`OFS_CMD, 32'h2);
    wr(`OFS_CTRL, 32'h0);
    // short interval keeps the run brief
    wr(`OFS_INTERVAL, 32'd10);
    wr(`OFS_CTRL, 32'h2);
    repeat (3)
    begin
        repeat (6) @(posedge core_clk);
        wr(`OFS_CMD, 32'h1);
    end
    repeat (9) @(posedge core_clk);
    #1;
    chk("early", wdog_overflow, 1'b0);
    @(posedge core_clk);
    #1;
    chk("overflow", wdog_overflow, 1'b1);
    wait_sd();
    chk("wd relay", relay_out, preset);
    chk("wd irq", irq, 1'b1);
    @(posedge core_clk);
    wr(`OFS_CMD, 32'h1);
    chk("sticky", wdog_overflow, 1'b1);
    wr(`OFS_CTRL, 32'h0);
    chk("ovf off", wdog_overflow, 1'b0);
    wr(`OFS_CMD, 32'h2);
    wr(`OFS_CTRL, 32'h28a);
    pull_bus <= 8'h20;
    wait_sd();
    chk("wd bus", relay_out, preset);
    @(posedge core_clk);
    wr(`OFS_CMD, 32'h10);
    chk("led", hot_swap_led, 1'b0);
    complete_run();
end
endmodule
